// ### hdl/fdr_pkg.sv
// package: register map, field layout and timing for the fan drive ramp and floor block
//
// Notes on behaviour
// [R1] control bits 2:0 pick the ramp rate of drive a instead of jumping
// [R2] rate codes 0..7 step duty by 1,2,3,4,8,12,24,48 per time slot
// [R3] ramp 33% to 100% takes about 35 s down to 0.8 s per code
// [R4] bit 3 enables ramping on drive a; rate field only acts while set
// [R5] sync bit 4 set: sense b, c and d measured in step with drive c
// [R6] sync bit clear: only sense c and d follow drive c; b measured alone
// [R7] auto mode, below start temp: bit 5 picks 0% or minimum duty for drive a
// [R8] auto mode, below start temp: bit 6 picks 0% or minimum duty for drive b
// [R9] auto mode, below start temp: bit 7 picks 0% or minimum duty for drive c
// [R10] once the configuration lock is set, writes to control are ignored
// [R11] control register resets to all zeros
// [R12] with ramping off, drive a takes each new duty at once
package fdr_pkg;

  // ****************************************
  // register map (offsets are word indices; byte address is index times four)
  // ****************************************
  localparam logic [9:0]  FDR_CTRL_IDX  = 10'h062;
  localparam logic [9:0]  FDR_LOCK_IDX  = 10'h040;
  localparam logic [9:0]  FDR_STAT_IDX  = 10'h041;
  localparam logic [11:0] FDR_CTRL_ADDR = {FDR_CTRL_IDX, 2'b00};
  localparam logic [11:0] FDR_LOCK_ADDR = {FDR_LOCK_IDX, 2'b00};
  localparam logic [11:0] FDR_STAT_ADDR = {FDR_STAT_IDX, 2'b00};

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int          FDR_LOCK_BIT  = 0;
  localparam logic [7:0]  FDR_CTRL_RST  = 8'h00;
  localparam logic        FDR_LOCK_RST  = 1'b0;
  localparam logic [7:0]  FDR_DUTY_OFF  = 8'h00;
  localparam logic [2:0]  FDR_SYNC_RST  = 3'h6;

  typedef struct packed {
    logic       below_floor_hold_3;
    logic       below_floor_hold_2;
    logic       below_floor_hold_1;
    logic       tach_sync_all;
    logic       ramp_on_1;
    logic [2:0] ramp_rate_sel_1;
  } fdr_ctrl_t;

  // one drive channel as handed over by the duty computation
  typedef struct packed {
    logic       below_start;
    logic [7:0] min_duty;
    logic [7:0] calc_duty;
  } fdr_chan_t;

  // ****************************************
  // ramp step table and timing
  // ****************************************
  localparam logic [7:0] FDR_STEP_TBL [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                              8'h08, 8'h0c, 8'h18, 8'h30};
  // slowest code: 33% (0x54) to 100% (0xff) is 171 steps of one in 35 s
  localparam int FDR_RAMP_FULL_MS   = 35000;
  localparam int FDR_RAMP_SPAN      = 171;
  localparam int FDR_CLK_KHZ        = 100000;
  localparam int FDR_SLOT_CYCLES    = (FDR_RAMP_FULL_MS / FDR_RAMP_SPAN) * FDR_CLK_KHZ;
  localparam int FDR_SLOT_CNT_W     = 25;

endpackage

// ### hdl/fdr_ramp.sv
// ramp stepper: walks drive a toward its target one time slot at a time
`timescale 1ns/100ps
`default_nettype none
module fdr_ramp
  import fdr_pkg::*;
#(
  parameter int SLOT_CYCLES = FDR_SLOT_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ramp_en,
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] target,
  output logic      [7:0] duty_q,
  output logic            ramp_active
);

  logic [FDR_SLOT_CNT_W-1:0] slot_cnt_q;
  logic [FDR_SLOT_CNT_W-1:0] slot_cnt_d;
  logic [7:0]                duty_d;
  logic [7:0]                step;
  logic [7:0]                gap;
  logic                      slot_tick;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    step       = FDR_STEP_TBL[rate_sel]; // R2
    gap        = (duty_q < target) ? (target - duty_q) : (duty_q - target);
    slot_tick  = (slot_cnt_q == FDR_SLOT_CNT_W'(SLOT_CYCLES - 1));
    slot_cnt_d = slot_cnt_q;
    duty_d     = duty_q;
    if (!ramp_en) begin
      duty_d     = target; // R12
      slot_cnt_d = '0;
    end else if (slot_tick) begin
      slot_cnt_d = '0;
      // clamp at the target so a large step never overshoots
      if (gap <= step) begin
        duty_d = target; // R1
      end else if (duty_q < target) begin
        duty_d = duty_q + step; // R3
      end else begin
        duty_d = duty_q - step;
      end
    end else begin
      slot_cnt_d = slot_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      slot_cnt_q <= '0;
      duty_q     <= FDR_DUTY_OFF;
    end else begin
      slot_cnt_q <= slot_cnt_d;
      duty_q     <= duty_d;
    end
  end

  assign ramp_active = ramp_en && (duty_q != target);

  // ****************************************
  // checks
  // ****************************************
  a_step_up_size: assert property (@(posedge mclk) disable iff (rst) // R2
    (ramp_en && slot_tick && duty_q < target && (target - duty_q) > step)
    |=> duty_q == $past(duty_q) + $past(step))
    else $error("ramp step differs from rate table");

  a_hold_in_slot: assert property (@(posedge mclk) disable iff (rst) // R3
    (ramp_en && $past(ramp_en) && !slot_tick) |=> $stable(duty_q))
    else $error("drive a moved between time slots");

endmodule
`default_nettype wire

// ### hdl/fdr_top.sv
// top: control register over apb, floor selection, ramp of drive a, tach sync select
`timescale 1ns/100ps
`default_nettype none
module fdr_top
  import fdr_pkg::*;
#(
  parameter int SLOT_CYCLES = FDR_SLOT_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // duty computation side
  input  wire logic        auto_mode,
  input  wire fdr_chan_t   chan_a,
  input  wire fdr_chan_t   chan_b,
  input  wire fdr_chan_t   chan_c,
  // drive outputs
  output logic      [7:0]  fan_drive_a,
  output logic      [7:0]  fan_drive_b,
  output logic      [7:0]  fan_drive_c,
  // 1: speed_sense_b/c/d measured in step with fan_drive_c
  output logic      [2:0]  tach_sync_sel,
  output logic             ramp_busy_a
);

  // ****************************************
  // apb decode
  // ****************************************
  logic      apb_access;
  logic      apb_wr;
  logic      hit_ctrl;
  logic      hit_lock;
  logic      hit_stat;
  logic      hit_any;

  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite;
  assign pready     = 1'b1;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_lock = 1'b0;
    hit_stat = 1'b0;
    if (paddr == FDR_CTRL_ADDR) begin
      hit_ctrl = 1'b1;
    end else if (paddr == FDR_LOCK_ADDR) begin
      hit_lock = 1'b1;
    end else if (paddr == FDR_STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any = hit_ctrl || hit_lock || hit_stat;
  // unmapped addresses answer with an error and read zero
  assign pslverr = apb_access && !hit_any;

  // ****************************************
  // control and lock registers
  // ****************************************
  fdr_ctrl_t ctrl_q;
  fdr_ctrl_t ctrl_d;
  logic      lock_q;
  logic      lock_d;

  always_comb begin
    ctrl_d = ctrl_q;
    lock_d = lock_q;
    // lock only sets; it is released by reset alone
    if (apb_wr && hit_lock && pwdata[FDR_LOCK_BIT]) begin
      lock_d = 1'b1;
    end
    if (apb_wr && hit_ctrl && !lock_q) begin // R10
      ctrl_d = fdr_ctrl_t'(pwdata[7:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= fdr_ctrl_t'(FDR_CTRL_RST); // R11
      lock_q <= FDR_LOCK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      lock_q <= lock_d;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      prdata_d = {24'h00_0000, ctrl_q};
    end else if (hit_lock) begin
      prdata_d = {31'h0000_0000, lock_q};
    end else if (hit_stat) begin
      prdata_d = {23'h00_0000, ramp_busy_a, fan_drive_a};
    end
  end

  // setup phase registers the word so it is stable in the access phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  // ****************************************
  // floor selection per drive
  // ****************************************
  fdr_chan_t  chans [3];
  logic [2:0] hold_sel;
  logic [7:0] floor_tgt [3];

  assign chans[0] = chan_a;
  assign chans[1] = chan_b;
  assign chans[2] = chan_c;
  assign hold_sel = {ctrl_q.below_floor_hold_3, ctrl_q.below_floor_hold_2,
                     ctrl_q.below_floor_hold_1};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_floor
      always_comb begin
        floor_tgt[gi] = chans[gi].calc_duty;
        if (auto_mode && chans[gi].below_start) begin
          // hold spins the fan slowly instead of stopping it
          floor_tgt[gi] = hold_sel[gi] ? chans[gi].min_duty : FDR_DUTY_OFF; // R7 R8 R9
        end
      end
    end
  endgenerate

  // ****************************************
  // drive outputs
  // ****************************************
  logic [7:0] drive_b_d;
  logic [7:0] drive_b_q;
  logic [7:0] drive_c_d;
  logic [7:0] drive_c_q;

  always_comb begin
    drive_b_d = floor_tgt[1]; // R8
    drive_c_d = floor_tgt[2]; // R9
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_b_q <= FDR_DUTY_OFF;
      drive_c_q <= FDR_DUTY_OFF;
    end else begin
      drive_b_q <= drive_b_d;
      drive_c_q <= drive_c_d;
    end
  end

  assign fan_drive_b = drive_b_q;
  assign fan_drive_c = drive_c_q;

  // the floor is applied before the ramp, so dropping to off also ramps
  fdr_ramp #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_ramp_a (
    .mclk        (mclk),
    .rst         (rst),
    .ramp_en     (ctrl_q.ramp_on_1),       // R4
    .rate_sel    (ctrl_q.ramp_rate_sel_1), // R1
    .target      (floor_tgt[0]),
    .duty_q      (fan_drive_a),
    .ramp_active (ramp_busy_a)
  );

  // ****************************************
  // tach sync selection
  // ****************************************
  logic [2:0] sync_d;
  logic [2:0] sync_q;

  always_comb begin
    sync_d = {2'b11, ctrl_q.tach_sync_all}; // R5 R6
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_q <= FDR_SYNC_RST;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign tach_sync_sel = sync_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_ctrl_write;
    apb_wr && hit_ctrl;
  endsequence

  sequence s_locked_write;
    lock_q ##0 s_ctrl_write;
  endsequence

  a_ctrl_reset_zero: assert property (@(posedge mclk) // R11
    rst |=> (ctrl_q == fdr_ctrl_t'(FDR_CTRL_RST)) && (fan_drive_a == FDR_DUTY_OFF))
    else $error("control not cleared by reset");

  a_lock_blocks_write: assert property (@(posedge mclk) disable iff (rst) // R10
    s_locked_write |=> $stable(ctrl_q))
    else $error("control changed while locked");

  a_ctrl_write_takes: assert property (@(posedge mclk) disable iff (rst) // R1
    (!lock_q ##0 s_ctrl_write) |=> ctrl_q == fdr_ctrl_t'($past(pwdata[7:0])))
    else $error("unlocked control write lost");

  a_floor_drive_a: assert property (@(posedge mclk) disable iff (rst) // R7
    (auto_mode && chan_a.below_start && !ctrl_q.ramp_on_1)
    |=> fan_drive_a == ($past(ctrl_q.below_floor_hold_1) ? $past(chan_a.min_duty)
                                                           : FDR_DUTY_OFF))
    else $error("drive a floor wrong below start temperature");

  a_floor_drive_b: assert property (@(posedge mclk) disable iff (rst) // R8
    (auto_mode && chan_b.below_start)
    |=> fan_drive_b == ($past(ctrl_q.below_floor_hold_2) ? $past(chan_b.min_duty)
                                                           : FDR_DUTY_OFF))
    else $error("drive b floor wrong below start temperature");

  a_floor_drive_c: assert property (@(posedge mclk) disable iff (rst) // R9
    (auto_mode && chan_c.below_start)
    |=> fan_drive_c == ($past(ctrl_q.below_floor_hold_3) ? $past(chan_c.min_duty)
                                                           : FDR_DUTY_OFF))
    else $error("drive c floor wrong below start temperature");

  a_tach_sync_sel: assert property (@(posedge mclk) disable iff (rst) // R5 R6
    1'b1 |=> tach_sync_sel == {2'b11, $past(ctrl_q.tach_sync_all)})
    else $error("tach sync selection does not follow sync bit");

  a_ramp_off_direct: assert property (@(posedge mclk) disable iff (rst) // R12
    (!ctrl_q.ramp_on_1) |=> fan_drive_a == $past(floor_tgt[0]))
    else $error("drive a did not jump with ramping off");

  a_ramp_busy_flag: assert property (@(posedge mclk) disable iff (rst) // R4
    ramp_busy_a |-> ctrl_q.ramp_on_1 && (fan_drive_a != floor_tgt[0]))
    else $error("ramp busy without ramping enabled");

  // ****************************************
  // register access and drive checks
  // ****************************************
  sequence s_ctrl_setup;
    psel && !penable && hit_ctrl;
  endsequence

  sequence s_stat_setup;
    psel && !penable && hit_stat;
  endsequence

  sequence s_lock_request;
    apb_wr && hit_lock && pwdata[FDR_LOCK_BIT];
  endsequence

  a_ctrl_read_back: assert property (@(posedge mclk) disable iff (rst) // R1
    s_ctrl_setup |=> prdata == {24'h00_0000, $past(ctrl_q)})
    else $error("control read back differs from register");

  a_stat_read_back: assert property (@(posedge mclk) disable iff (rst) // R4
    s_stat_setup |=> prdata == {23'h00_0000, $past(ramp_busy_a), $past(fan_drive_a)})
    else $error("status read back differs from drive a");

  a_lock_takes: assert property (@(posedge mclk) disable iff (rst) // R10
    s_lock_request |=> lock_q)
    else $error("lock request not taken");

  // only reset may release the lock, or locked writes could slip through
  a_lock_sticky: assert property (@(posedge mclk) disable iff (rst) // R10
    lock_q |=> lock_q)
    else $error("lock released without reset");

  a_drive_b_pass: assert property (@(posedge mclk) disable iff (rst) // R8
    !(auto_mode && chan_b.below_start) |=> fan_drive_b == $past(chan_b.calc_duty))
    else $error("drive b does not follow computed duty");

  a_drive_c_pass: assert property (@(posedge mclk) disable iff (rst) // R9
    !(auto_mode && chan_c.below_start) |=> fan_drive_c == $past(chan_c.calc_duty))
    else $error("drive c does not follow computed duty");

  // drives start off so no fan spins before software sets it up
  a_reset_outputs: assert property (@(posedge mclk) // R11
    rst |=> (fan_drive_b == FDR_DUTY_OFF) && (fan_drive_c == FDR_DUTY_OFF)
            && (tach_sync_sel == FDR_SYNC_RST) && (prdata == 32'h0000_0000))
    else $error("outputs not cleared by reset");

endmodule
`default_nettype wire

// ### tb/fdr_fan_model.sv
// partner model: fans whose tach pulse rate follows their drive duty
`timescale 1ns/100ps
`default_nettype none
module fdr_fan_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] fan_drive_a,
  input  wire logic [7:0] fan_drive_b,
  input  wire logic [7:0] fan_drive_c,
  input  wire logic [2:0] tach_sync_sel,
  output logic      [3:0] speed_sense
);
  logic [8:0] acc_a;
  logic [8:0] acc_b;
  logic [8:0] acc_c;
  // cleared on reset so unknown drives before reset never stick in the sums
  // a synced sense sees nothing while drive c is off, as a real shared fan would
  always @(posedge mclk) begin
    if (rst) begin
      acc_a       <= '0;
      acc_b       <= '0;
      acc_c       <= '0;
      speed_sense <= '0;
    end else begin
      acc_a <= {1'b0, acc_a[7:0]} + 9'(fan_drive_a);
      acc_b <= {1'b0, acc_b[7:0]} + 9'(fan_drive_b);
      acc_c <= {1'b0, acc_c[7:0]} + 9'(fan_drive_c);
      speed_sense[0] <= acc_a[8];
      speed_sense[1] <= acc_b[8] & (~tach_sync_sel[0] | (fan_drive_c != 8'h00));
      speed_sense[3:2] <= {2{acc_c[8]}};
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench: register access, floor choice, ramp stepping and tach sync
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import fdr_pkg::*;
;
  localparam int SLOT = 4;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, auto_mode, ramp_busy_a;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  fdr_chan_t   chan_a, chan_b, chan_c;
  logic [7:0]  fan_drive_a, fan_drive_b, fan_drive_c;
  logic [15:0] ra, rb, rc;
  logic [2:0]  tach_sync_sel;
  logic [3:0]  speed_sense;
  logic [32:0] exp_q[$];
  int          fails, num_checks, n;

  fdr_top #(.SLOT_CYCLES(SLOT)) dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auto_mode(auto_mode), .chan_a(chan_a), .chan_b(chan_b), .chan_c(chan_c),
    .fan_drive_a(fan_drive_a), .fan_drive_b(fan_drive_b), .fan_drive_c(fan_drive_c),
    .tach_sync_sel(tach_sync_sel), .ramp_busy_a(ramp_busy_a));
  fdr_fan_model u_fans (
    .mclk(mclk), .rst(rst), .fan_drive_a(fan_drive_a), .fan_drive_b(fan_drive_b),
    .fan_drive_c(fan_drive_c), .tach_sync_sel(tach_sync_sel), .speed_sense(speed_sense));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
    num_checks++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      fails++;
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // held until pready is seen; reads note {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(ex);
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // counts edges until drive a moves
  task automatic wait_a(output int cnt);
    logic [7:0] prev;
    prev = fan_drive_a;
    cnt = 0;
    while (fan_drive_a === prev && cnt < 200) begin
      @(posedge mclk);
      cnt++;
    end
    if (cnt >= 200) begin
      fails++;
      end_sim();
    end
  endtask

  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("read queue", 33'h0, 33'h1);
      end else begin
        chk("read data", exp_q.pop_front(), {pslverr, prdata});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h2dd71e1d));
    {rst, psel, penable, pwrite, auto_mode} = 5'h10;
    {paddr, pwdata} = '0;
    {chan_a, chan_b, chan_c} = '0;
    fails = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("sync sel", 33'h6, 33'(tach_sync_sel));
    apb(1'b0, FDR_CTRL_ADDR, 32'h0, 33'(FDR_CTRL_RST));
    apb(1'b1, FDR_CTRL_ADDR, 32'h10, 33'h0);
    @(posedge mclk);
    chk("sync sel", 33'h7, 33'(tach_sync_sel));
    chk("sense b", 33'h0, 33'(speed_sense[1]));
    apb(1'b0, FDR_CTRL_ADDR, 32'h0, 33'h10);
    auto_mode <= 1'b1;
    for (int h = 0; h < 8; h++) begin
      apb(1'b1, FDR_CTRL_ADDR, {24'h0, 3'(h), 5'h0}, 33'h0);
      ra = 16'($urandom);
      rb = 16'($urandom);
      rc = 16'($urandom);
      chan_a <= {1'b1, ra};
      chan_b <= {1'b1, rb};
      chan_c <= {1'b1, rc};
      repeat (2) @(posedge mclk);
      chk("drive a", h[0] ? 33'(ra[15:8]) : 33'h0, 33'(fan_drive_a));
      chk("drive b", h[1] ? 33'(rb[15:8]) : 33'h0, 33'(fan_drive_b));
      chk("drive c", h[2] ? 33'(rc[15:8]) : 33'h0, 33'(fan_drive_c));
    end
    chan_b <= {1'b0, rb};
    repeat (2) @(posedge mclk);
    chk("drive b", 33'(rb[7:0]), 33'(fan_drive_b));
    // ramp each code up from zero: first step size, then one slot to the next
    chan_a <= '0;
    apb(1'b1, FDR_CTRL_ADDR, 32'h0, 33'h0);
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, FDR_CTRL_ADDR, 32'h08 | 32'(r), 33'h0);
      chan_a <= {1'b0, 8'h00, 8'hff};
      wait_a(n);
      chk("step one", 33'(FDR_STEP_TBL[r]), 33'(fan_drive_a));
      chk("busy", 33'h1, 33'(ramp_busy_a));
      wait_a(n);
      chk("slot", 33'(SLOT), 33'(n));
      chk("step two", 33'(2 * FDR_STEP_TBL[r]), 33'(fan_drive_a));
      apb(1'b0, FDR_STAT_ADDR, 32'h0, 33'h100 | 33'(2 * FDR_STEP_TBL[r]));
      apb(1'b1, FDR_CTRL_ADDR, 32'h0, 33'h0);
      repeat (2) @(posedge mclk);
      chk("jump", 33'hff, 33'(fan_drive_a));
      chan_a <= '0;
      repeat (2) @(posedge mclk);
    end
    apb(1'b1, FDR_CTRL_ADDR, 32'h5a, 33'h0);
    apb(1'b1, FDR_LOCK_ADDR, 32'h1, 33'h0);
    apb(1'b1, FDR_CTRL_ADDR, 32'ha5, 33'h0);
    apb(1'b0, FDR_CTRL_ADDR, 32'h0, 33'h5a);
    apb(1'b0, 12'h004, 32'h0, {1'b1, 32'h0});
    repeat (2) @(posedge mclk);
    end_sim();
  end
endmodule
`default_nettype wire
